// *** design/vtsp_pkg.sv ***
// Shared constants and types for the transfer and shift port block
package vtsp_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int WORD_W = 4;
  localparam int ROW_WORDS = 512;
  localparam int ROW_W = ROW_WORDS * WORD_W;
  localparam int ROW_COUNT = 512;
  localparam logic [8:0] PTR_FIRST = 9'h000;
  localparam logic [8:0] PTR_LAST = 9'h1FF;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic MODE_RESET = 1'h0;
  localparam logic [3:0] WORD_RESET = 4'h0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic row_n;
    logic col_n;
    logic gate_n;
    logic mask_n;
    logic spg_n;
    logic [ADDR_W-1:0] addr;
  } vtsp_pins_type;

  localparam vtsp_pins_type PINS_IDLE = '{row_n: 1'h1, col_n: 1'h1,
    gate_n: 1'h1, mask_n: 1'h1, spg_n: 1'h1, addr: 9'h000};

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_READ   = 5'h02,
    ST_WRITE  = 5'h04,
    ST_PSEUDO = 5'h08,
    ST_OTHER  = 5'h10
  } vtsp_state_type;

  typedef struct packed {
    vtsp_pins_type s1;
    vtsp_pins_type s2;
    vtsp_pins_type p;
    vtsp_state_type st;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic out_mode;
    logic req_tgl;
    logic load_row;
    logic [ADDR_W-1:0] start;
    logic [ROW_W-1:0] row_data;
  } vtsp_core_type;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic mode_s1;
    logic mode_s2;
    logic req_s1;
    logic req_s2;
    logic req_p;
    logic [ADDR_W-1:0] ptr;
    logic [WORD_W-1:0] out_word;
  } vtsp_link_type;

endpackage

// *** design/vtsp_top.sv ***
// Transfer cycles, row array and circular shift port of the video memory
`timescale 1ns/1ps

module vtsp_top (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Memory controller strobes and address
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic transfer_or_output_gate_n,
  input wire logic mask_or_write_strobe_n,
  input wire logic [vtsp_pkg::ADDR_W-1:0] addr,
  // Shift port
  input wire logic shift_clock,
  input wire logic shift_port_gate_n,
  input wire logic [vtsp_pkg::WORD_W-1:0] shift_data_pins_in,
  output logic [vtsp_pkg::WORD_W-1:0] shift_data_pins_out,
  output logic shift_data_pins_oe
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [vtsp_pkg::ADDR_W-1:0] next_ptr(
    input logic [vtsp_pkg::ADDR_W-1:0] p);
    if (p == vtsp_pkg::PTR_LAST) begin
      return vtsp_pkg::PTR_FIRST;
    end
    return p + 9'h001;
  endfunction

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [vtsp_pkg::ROW_W-1:0] ram [vtsp_pkg::ROW_COUNT];
  logic [vtsp_pkg::WORD_W-1:0] sbuf [vtsp_pkg::ROW_WORDS];
  logic [vtsp_pkg::ROW_W-1:0] sbuf_flat;

  vtsp_pkg::vtsp_core_type c_q;
  vtsp_pkg::vtsp_core_type c_d;
  vtsp_pkg::vtsp_link_type l_q;
  vtsp_pkg::vtsp_link_type l_d;
  vtsp_pkg::vtsp_pins_type pins_in;

  logic row_fall;
  logic row_rise;
  logic col_fall;
  logic gate_rise;
  logic is_xfer;
  logic ram_we;
  logic link_load;
  logic load_row_now;
  logic sbuf_we;

  assign pins_in = '{row_n: row_strobe_n, col_n: column_strobe_n,
    gate_n: transfer_or_output_gate_n, mask_n: mask_or_write_strobe_n,
    spg_n: shift_port_gate_n, addr: addr};

  // Shift clock is held still during write decode, so buffer is quiet
  always_comb begin
    sbuf_flat = '0;
    for (int i = 0; i < vtsp_pkg::ROW_WORDS; i++) begin
      sbuf_flat[i*vtsp_pkg::WORD_W +: vtsp_pkg::WORD_W] = sbuf[i];
    end
  end

  // ------------------------------------------------------------
  // Strobe side on the system clock
  // ------------------------------------------------------------
  assign row_fall = c_q.p.row_n & ~c_q.s2.row_n;
  assign row_rise = ~c_q.p.row_n & c_q.s2.row_n;
  assign col_fall = c_q.p.col_n & ~c_q.s2.col_n;
  assign gate_rise = ~c_q.p.gate_n & c_q.s2.gate_n;
  assign is_xfer = c_q.s2.col_n & ~c_q.s2.gate_n;

  always_comb begin
    c_d = c_q;
    ram_we = 1'h0;
    c_d.s1 = pins_in;
    c_d.s2 = c_q.s1;
    c_d.p = c_q.s2;
    case (c_q.st)
      vtsp_pkg::ST_IDLE: begin
        if (row_fall) begin
          if (is_xfer) begin
            c_d.row = c_q.s2.addr;
            if (c_q.s2.mask_n) begin
              c_d.st = vtsp_pkg::ST_READ;
            end else if (c_q.s2.spg_n) begin
              c_d.st = vtsp_pkg::ST_PSEUDO;
              c_d.out_mode = 1'h0;
            end else begin
              c_d.st = vtsp_pkg::ST_WRITE;
              c_d.out_mode = 1'h0;
              ram_we = 1'h1;
            end
          end else begin
            c_d.st = vtsp_pkg::ST_OTHER;
          end
        end
      end
      vtsp_pkg::ST_READ: begin
        if (col_fall) begin
          c_d.col = c_q.s2.addr;
        end
        if (gate_rise) begin
          c_d.row_data = ram[c_q.row];
          c_d.start = col_fall ? c_q.s2.addr : c_q.col;
          c_d.load_row = 1'h1;
          c_d.req_tgl = ~c_q.req_tgl;
          c_d.out_mode = 1'h1;
        end
        if (row_rise) begin
          c_d.st = vtsp_pkg::ST_IDLE;
        end
      end
      vtsp_pkg::ST_WRITE, vtsp_pkg::ST_PSEUDO: begin
        if (col_fall) begin
          c_d.col = c_q.s2.addr;
          c_d.start = c_q.s2.addr;
          c_d.load_row = 1'h0;
          c_d.req_tgl = ~c_q.req_tgl;
        end
        if (row_rise) begin
          c_d.st = vtsp_pkg::ST_IDLE;
        end
      end
      vtsp_pkg::ST_OTHER: begin
        if (row_rise) begin
          c_d.st = vtsp_pkg::ST_IDLE;
        end
      end
      default: begin
        c_d.st = vtsp_pkg::ST_IDLE;
      end
    endcase
    if (!rst_n) begin
      c_d = '0;
      c_d.s1 = vtsp_pkg::PINS_IDLE;
      c_d.s2 = vtsp_pkg::PINS_IDLE;
      c_d.p = vtsp_pkg::PINS_IDLE;
      c_d.st = vtsp_pkg::ST_IDLE;
      c_d.out_mode = vtsp_pkg::MODE_RESET;
      ram_we = 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    c_q <= c_d;
  end

  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram[c_q.s2.addr] <= sbuf_flat;
    end
  end

  // ------------------------------------------------------------
  // Shift port on the shift clock
  // ------------------------------------------------------------
  // Payload (start, load_row, row_data) is stable while the toggle moves
  assign link_load = l_q.req_s2 ^ l_q.req_p;

  always_comb begin
    l_d = l_q;
    load_row_now = 1'h0;
    sbuf_we = 1'h0;
    l_d.rst_s1 = rst_n;
    l_d.rst_s2 = l_q.rst_s1;
    l_d.mode_s1 = c_q.out_mode;
    l_d.mode_s2 = l_q.mode_s1;
    l_d.req_s1 = c_q.req_tgl;
    l_d.req_s2 = l_q.req_s1;
    l_d.req_p = l_q.req_s2;
    if (!l_q.rst_s2) begin
      l_d.mode_s2 = vtsp_pkg::MODE_RESET;
      l_d.req_s2 = 1'h0;
      l_d.req_p = 1'h0;
      l_d.ptr = vtsp_pkg::PTR_FIRST;
      l_d.out_word = vtsp_pkg::WORD_RESET;
    end else if (link_load) begin
      l_d.ptr = c_q.start;
      load_row_now = c_q.load_row;
    end else begin
      l_d.ptr = next_ptr(l_q.ptr);
      if (l_q.mode_s2) begin
        l_d.out_word = sbuf[l_q.ptr];
      end else if (!shift_port_gate_n) begin
        sbuf_we = 1'h1;
      end
    end
  end

  always_ff @(posedge shift_clock) begin
    l_q <= l_d;
  end

  always_ff @(posedge shift_clock) begin
    if (load_row_now) begin
      for (int i = 0; i < vtsp_pkg::ROW_WORDS; i++) begin
        sbuf[i] <= c_q.row_data[i*vtsp_pkg::WORD_W +: vtsp_pkg::WORD_W];
      end
    end else if (sbuf_we) begin
      sbuf[l_q.ptr] <= shift_data_pins_in;
    end
  end

  assign shift_data_pins_out = l_q.out_word;
  assign shift_data_pins_oe = l_q.mode_s2 & ~shift_port_gate_n;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_read_decode: assert property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_IDLE && row_fall && is_xfer && c_q.s2.mask_n
    |=> c_q.st == vtsp_pkg::ST_READ)
    else $error("read transfer not decoded");

  a_write_decode: assert property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_IDLE && row_fall && is_xfer &&
    !c_q.s2.mask_n && !c_q.s2.spg_n
    |=> c_q.st == vtsp_pkg::ST_WRITE && !c_q.out_mode)
    else $error("write transfer not decoded");

  a_pseudo_decode: assert property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_IDLE && row_fall && is_xfer &&
    !c_q.s2.mask_n && c_q.s2.spg_n
    |=> c_q.st == vtsp_pkg::ST_PSEUDO && !c_q.out_mode &&
    $stable(c_q.req_tgl))
    else $error("pseudo write not decoded");

  a_row_latch: assert property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_IDLE && row_fall && is_xfer
    |=> c_q.row == $past(c_q.s2.addr))
    else $error("transfer row not latched");

  a_read_done: assert property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_READ && gate_rise
    |=> c_q.out_mode && c_q.load_row && c_q.req_tgl != $past(c_q.req_tgl))
    else $error("read transfer did not complete");

  a_type_hold: assert property (@(posedge clk) disable iff (!rst_n)
    c_q.st != vtsp_pkg::ST_IDLE && !row_rise |=> $stable(c_q.st))
    else $error("transfer type changed early");

  a_mode_input: assert property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_WRITE |-> !c_q.out_mode)
    else $error("pins left in output mode on write");

  a_ptr_step: assert property (@(posedge shift_clock)
    disable iff (!l_q.rst_s2)
    !link_load |=> l_q.ptr == next_ptr($past(l_q.ptr)))
    else $error("pointer did not advance");

  a_ptr_wrap: assert property (@(posedge shift_clock)
    disable iff (!l_q.rst_s2)
    !link_load && l_q.ptr == vtsp_pkg::PTR_LAST
    |=> l_q.ptr == vtsp_pkg::PTR_FIRST)
    else $error("pointer did not wrap");

  a_ptr_start: assert property (@(posedge shift_clock)
    disable iff (!l_q.rst_s2)
    link_load |=> l_q.ptr == $past(c_q.start))
    else $error("pointer start not loaded");

  a_gate_disabled: assert property (@(posedge shift_clock)
    disable iff (!l_q.rst_s2)
    shift_port_gate_n && !link_load ##1 !link_load
    |=> l_q.ptr != $past(l_q.ptr, 2))
    else $error("pointer stalled while disabled");

  a_first_word: assert property (@(posedge shift_clock)
    disable iff (!l_q.rst_s2)
    link_load && c_q.load_row && l_q.mode_s2 ##1 !link_load
    |=> shift_data_pins_out == $past(sbuf[l_q.ptr]))
    else $error("first word not shifted out");

  a_other_decode: assert property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_IDLE && row_fall && !is_xfer
    |=> c_q.st == vtsp_pkg::ST_OTHER)
    else $error("plain row cycle taken as transfer");

  a_idle_return: assert property (@(posedge clk) disable iff (!rst_n)
    c_q.st != vtsp_pkg::ST_IDLE && row_rise
    |=> c_q.st == vtsp_pkg::ST_IDLE)
    else $error("row cycle did not end");

  a_mode_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(c_q.st == vtsp_pkg::ST_READ && gate_rise) &&
    !(c_q.st == vtsp_pkg::ST_IDLE && row_fall && is_xfer)
    |=> $stable(c_q.out_mode))
    else $error("pin direction changed outside a transfer");

  a_pseudo_nocopy: assert property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_PSEUDO && col_fall |=> !c_q.load_row)
    else $error("pseudo write requested a row load");

  a_write_start: assert property (@(posedge clk) disable iff (!rst_n)
    (c_q.st == vtsp_pkg::ST_WRITE || c_q.st == vtsp_pkg::ST_PSEUDO) &&
    col_fall |=> c_q.start == $past(c_q.s2.addr))
    else $error("write start pointer not latched");

  a_read_start: assert property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_READ && gate_rise && !col_fall
    |=> c_q.start == $past(c_q.col))
    else $error("read start pointer not latched");

  a_load_noshift: assert property (@(posedge shift_clock)
    disable iff (!l_q.rst_s2)
    link_load |=> $stable(shift_data_pins_out))
    else $error("load edge shifted a word");

  a_input_quiet: assert property (@(posedge shift_clock)
    disable iff (!l_q.rst_s2)
    !l_q.mode_s2 |=> $stable(shift_data_pins_out))
    else $error("output word moved in input mode");

  c_read_xfer: cover property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_READ && gate_rise);
  c_write_xfer: cover property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_WRITE && col_fall);
  c_pseudo_xfer: cover property (@(posedge clk) disable iff (!rst_n)
    c_q.st == vtsp_pkg::ST_PSEUDO && row_rise);
  c_ptr_wrap: cover property (@(posedge shift_clock)
    disable iff (!l_q.rst_s2)
    l_q.ptr == vtsp_pkg::PTR_LAST && !link_load);

endmodule

// *** verif/vtsp_ctrl_model.sv ***
// Controller-side model of the shift port: shift clock, gate and data
`timescale 1ns/1ps

module vtsp_ctrl_model (
  // Shift port driven by the controller
  output logic shift_clock,
  output logic shift_port_gate_n,
  output logic [vtsp_pkg::WORD_W-1:0] shift_data_pins_in,
  // Shift port driven by the block
  input wire logic [vtsp_pkg::WORD_W-1:0] shift_data_pins_out,
  input wire logic shift_data_pins_oe
);
  logic [vtsp_pkg::WORD_W-1:0] drv_q;
  logic wr_q;

  // Block wins while it drives; released data shows the inverse
  assign shift_data_pins_in = shift_data_pins_oe ? shift_data_pins_out :
    (wr_q ? drv_q : ~drv_q);

  // Clock rests low between pulses so transfers see a still clock
  initial begin
    shift_clock = 1'h0;
    shift_port_gate_n = 1'h1;
    drv_q = 4'h0;
    wr_q = 1'h0;
  end

  task automatic hold_gate(input logic g);
    shift_port_gate_n = g;
  endtask

  // One 6 ns shift period; data held until the rising edge has passed
  task automatic pulse(input logic g, input logic w, input logic [3:0] d);
    shift_port_gate_n = g;
    wr_q = w;
    drv_q = d;
    #3 shift_clock = 1'h1;
    #3 shift_clock = 1'h0;
    wr_q = 1'h0;
  endtask
endmodule

// *** verif/vtsp_tb_top.sv ***
// Self-checking bench for the transfer and shift port block
`timescale 1ns/1ps
`define CHK(a, b) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); \
  end \
end

module vtsp_tb_top;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic row_strobe_n = 1'h1;
  logic column_strobe_n = 1'h1;
  logic transfer_or_output_gate_n = 1'h1;
  logic mask_or_write_strobe_n = 1'h1;
  logic [8:0] addr = 9'h000;
  logic shift_clock, shift_port_gate_n, shift_data_pins_oe;
  logic [3:0] shift_data_pins_in, shift_data_pins_out;
  logic [3:0] exp_word [0:5] = '{4'hA, 4'h5, 4'h3, 4'hC, 4'h9, 4'h6};
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  vtsp_top vtsp_top_inst (.clk(clk), .rst_n(rst_n),
    .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .transfer_or_output_gate_n(transfer_or_output_gate_n),
    .mask_or_write_strobe_n(mask_or_write_strobe_n), .addr(addr),
    .shift_clock(shift_clock), .shift_port_gate_n(shift_port_gate_n),
    .shift_data_pins_in(shift_data_pins_in),
    .shift_data_pins_out(shift_data_pins_out),
    .shift_data_pins_oe(shift_data_pins_oe));

  vtsp_ctrl_model vtsp_ctrl_model_inst (.shift_clock(shift_clock),
    .shift_port_gate_n(shift_port_gate_n),
    .shift_data_pins_in(shift_data_pins_in),
    .shift_data_pins_out(shift_data_pins_out),
    .shift_data_pins_oe(shift_data_pins_oe));

  always #50 clk = ~clk;

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One row cycle; strobe levels kept for four system clocks each
  task automatic xfer(input logic g, input logic m, input logic s,
                      input logic [8:0] row, input logic [8:0] col);
    vtsp_ctrl_model_inst.hold_gate(s);
    transfer_or_output_gate_n = g;
    mask_or_write_strobe_n = m;
    addr = row;
    step(4);
    row_strobe_n = 1'h0;
    step(4);
    addr = col;
    step(4);
    column_strobe_n = 1'h0;
    step(4);
    transfer_or_output_gate_n = 1'h1;
    mask_or_write_strobe_n = 1'h1;
    step(4);
    row_strobe_n = 1'h1;
    column_strobe_n = 1'h1;
    step(4);
  endtask

  // Three edges with access disabled let the start pointer land
  task automatic load3;
    repeat (3) vtsp_ctrl_model_inst.pulse(1'h1, 1'h0, 4'h0);
  endtask

  task automatic test_fill;
    xfer(1'h0, 1'h0, 1'h1, 9'h003, 9'h1FE);
    load3();
    `CHK(shift_data_pins_oe, 1'h0)
    for (int i = 0; i < 6; i++) begin
      vtsp_ctrl_model_inst.pulse(1'h0, 1'h1, exp_word[i]);
      `CHK(shift_data_pins_oe, 1'h0)
    end
    xfer(1'h0, 1'h0, 1'h0, 9'h005, 9'h000);
    load3();
    xfer(1'h0, 1'h0, 1'h0, 9'h006, 9'h000);
    load3();
    vtsp_ctrl_model_inst.hold_gate(1'h0);
    `CHK(shift_data_pins_oe, 1'h0)
    $display("test_fill done");
  endtask

  task automatic test_read;
    xfer(1'h0, 1'h1, 1'h0, 9'h005, 9'h1FE);
    load3();
    for (int i = 0; i < 3; i++) begin
      vtsp_ctrl_model_inst.pulse(1'h0, 1'h0, 4'h0);
      `CHK(shift_data_pins_out, exp_word[i])
      `CHK(shift_data_pins_oe, 1'h1)
    end
    repeat (2) vtsp_ctrl_model_inst.pulse(1'h1, 1'h0, 4'h0);
    `CHK(shift_data_pins_oe, 1'h0)
    vtsp_ctrl_model_inst.pulse(1'h0, 1'h0, 4'h0);
    `CHK(shift_data_pins_out, exp_word[5])
    $display("test_read done");
  endtask

  task automatic test_realtime;
    xfer(1'h0, 1'h1, 1'h0, 9'h005, 9'h1FF);
    load3();
    vtsp_ctrl_model_inst.pulse(1'h0, 1'h0, 4'h0);
    `CHK(shift_data_pins_out, exp_word[1])
    vtsp_ctrl_model_inst.pulse(1'h0, 1'h0, 4'h0);
    `CHK(shift_data_pins_out, exp_word[2])
    xfer(1'h1, 1'h1, 1'h0, 9'h006, 9'h000);
    vtsp_ctrl_model_inst.pulse(1'h0, 1'h0, 4'h0);
    `CHK(shift_data_pins_out, exp_word[3])
    $display("test_realtime done");
  endtask

  initial begin
    repeat (10) vtsp_ctrl_model_inst.pulse(1'h1, 1'h0, 4'h0);
    step(5);
    rst_n = 1'h1;
    // Shift side needs two edges to leave its reset synchroniser
    repeat (3) vtsp_ctrl_model_inst.pulse(1'h1, 1'h0, 4'h0);
    step(2000);
    repeat (8) xfer(1'h1, 1'h1, 1'h1, 9'h000, 9'h000);
    test_fill();
    test_read();
    test_realtime();
    end_of_test();
  end
endmodule
